// *** hdl/typec_cc_defines.vh ***
/*
  Shared constants of the Type-C configuration-channel controller:
  register offsets, field positions, role and level codes, timing figures.
  Assumes a 100 MHz pclk; cycle counts are derived from times in ms.
*/
`ifndef TYPEC_CC_DEFINES_VH
`define TYPEC_CC_DEFINES_VH

// ==========================================================
// clock and timing
`define CLK_CYCLES_PER_MS 100000
`define CC_DEBOUNCE_MS 168
`define BUS_POWER_DEBOUNCE_MS 2
`define ROLE_TOGGLE_PERIOD_MS 75
`define SOURCE_SHARE_PERCENT 30
`define CC_DEBOUNCE_CYCLES (`CC_DEBOUNCE_MS * `CLK_CYCLES_PER_MS)
`define BUS_POWER_DEBOUNCE_CYCLES (`BUS_POWER_DEBOUNCE_MS * `CLK_CYCLES_PER_MS)
`define ROLE_TOGGLE_CYCLES (`ROLE_TOGGLE_PERIOD_MS * `CLK_CYCLES_PER_MS)
`define SOURCE_SHARE_CYCLES (`ROLE_TOGGLE_CYCLES * `SOURCE_SHARE_PERCENT / 100)

// ==========================================================
// register byte offsets
`define REG_IRQ_STATUS 12'h000
`define REG_IRQ_MASK 12'h004
`define REG_PORT_STATE 12'h008

// ==========================================================
// event bits of status and mask
`define EV_ATTACH 0
`define EV_DETACH 1
`define EV_BUS_POWER 2
`define EV_WIDTH 3
`define IRQ_MASK_RESET 3'h0

// ==========================================================
// port state fields
`define PS_STATE_LSB 0
`define PS_ROLE_LSB 4
`define PS_ORIENT_BIT 6
`define PS_BUS_POWER_BIT 7
`define PS_SRC_PHASE_BIT 8
`define PS_CUR_LSB 9

// ==========================================================
// roles and current levels
`define ROLE_SOURCE 2'h0
`define ROLE_SINK 2'h1
`define ROLE_DUAL 2'h2
`define CUR_NONE 2'h0
`define CUR_DEFAULT 2'h1
`define CUR_MEDIUM 2'h2
`define CUR_HIGH 2'h3

`endif

// *** hdl/stable_filter.v ***
/*
  Debounce filter: output follows the input only after the input has held
  a new value for LIMIT consecutive clocks.
  Assumes the input is synchronous to clk.
*/
module stable_filter #(
  parameter LIMIT = 200000,
  parameter CNT_W = 25
) (
  input wire clk,
  input wire rst_n,
  input wire raw_in,
  output reg stable_out
);
  reg [CNT_W-1:0] count_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {CNT_W{1'b0}};
      stable_out <= 1'b0;
    end else if (raw_in == stable_out) begin
      count_reg <= {CNT_W{1'b0}};
    end else if (count_reg == LIMIT[CNT_W-1:0] - 1'b1) begin
      // held for LIMIT clocks: take the new value and clear the count
      count_reg <= {CNT_W{1'b0}};
      stable_out <= raw_in;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end
endmodule // stable_filter

// *** hdl/role_toggle_timer.v ***
/*
  Dual-role toggle timer: src_phase is high for SRC_CYCLES of every
  PERIOD cycles while run is high, low and reset otherwise.
  Assumes SRC_CYCLES < PERIOD.
*/
module role_toggle_timer #(
  parameter PERIOD = 7500000,
  parameter SRC_CYCLES = 2250000,
  parameter CNT_W = 23
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  output reg src_phase
);
  reg [CNT_W-1:0] count_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {CNT_W{1'b0}};
      src_phase <= 1'b0;
    end else if (!run) begin
      // sink share first, so a fresh toggle starts as sink
      count_reg <= {CNT_W{1'b0}};
      src_phase <= 1'b0;
    end else begin
      if (count_reg == PERIOD[CNT_W-1:0] - 1'b1) begin
        count_reg <= {CNT_W{1'b0}};
      end else begin
        count_reg <= count_reg + 1'b1;
      end
      src_phase <= (count_reg >= (PERIOD[CNT_W-1:0] - SRC_CYCLES[CNT_W-1:0] - 1'b1)) &&
        (count_reg != PERIOD[CNT_W-1:0] - 1'b1);
    end
  end
endmodule // role_toggle_timer

// *** hdl/typec_cc_port_controller.v ***
/*
  Type-C configuration-channel port controller with an APB register file.
  Holds the attach state machine, role strap decode, current advertisement
  and detection, orientation, VCONN steering and interrupt logic.
  Assumes CC comparator results, strap and select levels arrive as digital
  inputs synchronous to pclk (100 MHz); open-drain pins are resolved outside.
*/
// Chosen here: the register offsets and register access over APB.
`include "typec_cc_defines.vh"

module typec_cc_port_controller #(
  parameter CC_DEBOUNCE_CYCLES = `CC_DEBOUNCE_CYCLES,
  parameter BUS_POWER_DEBOUNCE_CYCLES = `BUS_POWER_DEBOUNCE_CYCLES,
  parameter ROLE_TOGGLE_CYCLES = `ROLE_TOGGLE_CYCLES,
  parameter SOURCE_SHARE_CYCLES = `SOURCE_SHARE_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire strap_high,
  input wire strap_low,
  input wire cur_sel_mid,
  input wire cur_sel_high,
  input wire bus_power_sense,
  input wire cc1_rd_seen,
  input wire cc2_rd_seen,
  input wire cc1_ra_seen,
  input wire cc2_ra_seen,
  input wire [1:0] cc1_rp_level,
  input wire [1:0] cc2_rp_level,
  output reg cc_pullup_en,
  output reg [1:0] rp_level,
  output reg cc_pulldown_en,
  output reg vconn_cc1_en,
  output reg vconn_cc2_en,
  output reg current_ind_a_out,
  output reg current_ind_a_oe_n,
  output reg current_ind_b_out,
  output reg current_ind_b_oe_n,
  output reg orientation_out,
  output reg orientation_oe_n,
  output reg source_attach_flag_out,
  output reg source_attach_flag_oe_n
);
  // ==========================================================
  // states
  localparam [2:0] ST_UNATT_SNK = 3'h0;
  localparam [2:0] ST_WAIT_SNK = 3'h1;
  localparam [2:0] ST_ATT_SNK = 3'h2;
  localparam [2:0] ST_UNATT_SRC = 3'h3;
  localparam [2:0] ST_WAIT_SRC = 3'h4;
  localparam [2:0] ST_ATT_SRC = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] role_reg;
  reg role_taken_reg;
  reg orient_reg;
  reg orient_next;
  reg [`EV_WIDTH-1:0] status_reg;
  reg [`EV_WIDTH-1:0] mask_reg;
  reg bus_power_prev_reg;
  wire bus_power_ok;
  wire cc_stable;
  wire src_phase;
  wire cc_raw;
  wire is_source_state;
  wire toggle_run;
  wire attach_ev;
  wire detach_ev;
  wire bus_power_ev;
  wire [1:0] snk_level;
  wire [1:0] sel_level;
  wire apb_write;
  wire [`EV_WIDTH-1:0] w1c_bits;

  // ==========================================================
  // role strap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_reg <= `ROLE_SINK;
      role_taken_reg <= 1'b0;
    end else if (!role_taken_reg) begin
      // one capture at the first edge after release, frozen after
      role_taken_reg <= 1'b1;
      if (strap_high) begin
        role_reg <= `ROLE_SOURCE;
      end else if (strap_low) begin
        role_reg <= `ROLE_SINK;
      end else begin
        role_reg <= `ROLE_DUAL;
      end
    end
  end

  // ==========================================================
  // filters and toggle
  assign is_source_state = (state_reg == ST_UNATT_SRC) || (state_reg == ST_WAIT_SRC) ||
    (state_reg == ST_ATT_SRC);
  // sink sees a remote Rp on exactly one line, source sees a remote Rd
  assign cc_raw = is_source_state ? (cc1_rd_seen ^ cc2_rd_seen) :
    ((cc1_rp_level != `CUR_NONE) ^ (cc2_rp_level != `CUR_NONE));

  stable_filter #(
    .LIMIT(CC_DEBOUNCE_CYCLES),
    .CNT_W(25)
  ) u_cc_filter (
    .clk(pclk),
    .rst_n(presetn),
    .raw_in(cc_raw),
    .stable_out(cc_stable)
  );

  stable_filter #(
    .LIMIT(BUS_POWER_DEBOUNCE_CYCLES),
    .CNT_W(25)
  ) u_bus_power_filter (
    .clk(pclk),
    .rst_n(presetn),
    .raw_in(bus_power_sense),
    .stable_out(bus_power_ok)
  );

  assign toggle_run = role_taken_reg && (role_reg == `ROLE_DUAL) &&
    ((state_reg == ST_UNATT_SNK) || (state_reg == ST_UNATT_SRC));

  role_toggle_timer #(
    .PERIOD(ROLE_TOGGLE_CYCLES),
    .SRC_CYCLES(SOURCE_SHARE_CYCLES),
    .CNT_W(25)
  ) u_toggle (
    .clk(pclk),
    .rst_n(presetn),
    .run(toggle_run),
    .src_phase(src_phase)
  );

  // ==========================================================
  // attach state machine
  always @* begin
    state_next = state_reg;
    orient_next = orient_reg;
    case (state_reg)
      ST_UNATT_SNK: begin
        if (role_taken_reg && role_reg == `ROLE_SOURCE) begin
          state_next = ST_UNATT_SRC;
        end else if (cc_raw && role_taken_reg) begin
          state_next = ST_WAIT_SNK;
        end else if (role_reg == `ROLE_DUAL && src_phase) begin
          state_next = ST_UNATT_SRC;
        end
      end
      ST_WAIT_SNK: begin
        if (!cc_raw) begin
          state_next = ST_UNATT_SNK;
        end else if (cc_stable && bus_power_ok) begin
          state_next = ST_ATT_SNK;
          orient_next = (cc2_rp_level != `CUR_NONE);
        end
      end
      ST_ATT_SNK: begin
        if (!cc_stable || !bus_power_ok) begin
          state_next = ST_UNATT_SNK;
        end
      end
      ST_UNATT_SRC: begin
        if (cc_raw) begin
          state_next = ST_WAIT_SRC;
        end else if (role_reg == `ROLE_DUAL && !src_phase) begin
          state_next = ST_UNATT_SNK;
        end
      end
      ST_WAIT_SRC: begin
        if (!cc_raw) begin
          state_next = ST_UNATT_SRC;
        end else if (cc_stable) begin
          state_next = ST_ATT_SRC;
          orient_next = cc2_rd_seen;
        end
      end
      ST_ATT_SRC: begin
        if (!cc_stable) begin
          // dual role goes back to the sink side of the toggle
          state_next = (role_reg == `ROLE_DUAL) ? ST_UNATT_SNK : ST_UNATT_SRC;
        end
      end
      default: begin
        state_next = ST_UNATT_SNK;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_UNATT_SNK;
      orient_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      orient_reg <= orient_next;
    end
  end

  // ==========================================================
  // termination and indicator outputs
  assign sel_level = cur_sel_high ? `CUR_HIGH :
    (cur_sel_mid ? `CUR_MEDIUM : `CUR_DEFAULT);
  // next orientation, so the indicators are already right at the attach edge
  assign snk_level = orient_next ? cc2_rp_level : cc1_rp_level;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_pullup_en <= 1'b0;
      cc_pulldown_en <= 1'b1;
      rp_level <= `CUR_DEFAULT;
      vconn_cc1_en <= 1'b0;
      vconn_cc2_en <= 1'b0;
      current_ind_a_out <= 1'b0;
      current_ind_a_oe_n <= 1'b1;
      current_ind_b_out <= 1'b0;
      current_ind_b_oe_n <= 1'b1;
      orientation_out <= 1'b0;
      orientation_oe_n <= 1'b1;
      source_attach_flag_out <= 1'b0;
      source_attach_flag_oe_n <= 1'b1;
    end else begin
      cc_pullup_en <= (state_next == ST_UNATT_SRC) || (state_next == ST_WAIT_SRC) ||
        (state_next == ST_ATT_SRC);
      cc_pulldown_en <= !((state_next == ST_UNATT_SRC) || (state_next == ST_WAIT_SRC) ||
        (state_next == ST_ATT_SRC));
      rp_level <= sel_level;
      // vconn goes to the unused line only when it shows Ra
      vconn_cc1_en <= (state_next == ST_ATT_SRC) && orient_next && cc1_ra_seen;
      vconn_cc2_en <= (state_next == ST_ATT_SRC) && !orient_next && cc2_ra_seen;
      if (state_next == ST_ATT_SNK) begin
        current_ind_a_oe_n <= (snk_level == `CUR_DEFAULT);
        current_ind_b_oe_n <= (snk_level == `CUR_MEDIUM);
      end else begin
        current_ind_a_oe_n <= 1'b1;
        current_ind_b_oe_n <= 1'b1;
      end
      if ((state_next == ST_ATT_SNK) || (state_next == ST_ATT_SRC)) begin
        orientation_oe_n <= orient_next;
      end else begin
        orientation_oe_n <= 1'b1;
      end
      source_attach_flag_oe_n <= (state_next != ST_ATT_SRC);
    end
  end

  // ==========================================================
  // events and interrupt
  assign attach_ev = ((state_next == ST_ATT_SNK) || (state_next == ST_ATT_SRC)) &&
    (state_reg != state_next);
  assign detach_ev = ((state_reg == ST_ATT_SNK) || (state_reg == ST_ATT_SRC)) &&
    (state_reg != state_next);
  assign bus_power_ev = bus_power_ok ^ bus_power_prev_reg;
  assign apb_write = psel && penable && pready && pwrite;
  assign w1c_bits = (apb_write && paddr == `REG_IRQ_STATUS) ? pwdata[`EV_WIDTH-1:0] :
    {`EV_WIDTH{1'b0}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= {`EV_WIDTH{1'b0}};
      mask_reg <= `IRQ_MASK_RESET;
      bus_power_prev_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      bus_power_prev_reg <= bus_power_ok;
      // a new event beats a clear in the same cycle
      status_reg <= (status_reg & ~w1c_bits) | {bus_power_ev, detach_ev, attach_ev};
      if (apb_write && paddr == `REG_IRQ_MASK) begin
        mask_reg <= pwdata[`EV_WIDTH-1:0];
      end
      irq <= |(((status_reg & ~w1c_bits) | {bus_power_ev, detach_ev, attach_ev}) &
        ((apb_write && paddr == `REG_IRQ_MASK) ? pwdata[`EV_WIDTH-1:0] : mask_reg));
    end
  end

  // ==========================================================
  // apb slave, one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !((paddr == `REG_IRQ_STATUS) || (paddr == `REG_IRQ_MASK) ||
          ((paddr == `REG_PORT_STATE) && !pwrite));
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            `REG_IRQ_STATUS: begin
              prdata[`EV_WIDTH-1:0] <= status_reg;
            end
            `REG_IRQ_MASK: begin
              prdata[`EV_WIDTH-1:0] <= mask_reg;
            end
            `REG_PORT_STATE: begin
              prdata[`PS_STATE_LSB+2:`PS_STATE_LSB] <= state_reg;
              prdata[`PS_ROLE_LSB+1:`PS_ROLE_LSB] <= role_reg;
              prdata[`PS_ORIENT_BIT] <= orient_reg;
              prdata[`PS_BUS_POWER_BIT] <= bus_power_ok;
              prdata[`PS_SRC_PHASE_BIT] <= src_phase;
              prdata[`PS_CUR_LSB+1:`PS_CUR_LSB] <= snk_level;
            end
            default: begin
              prdata <= 32'h0000_0000;
            end
          endcase
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // typec_cc_port_controller

// *** verif/typec_cc_port_controller_chk.sv ***
/*
  Checker for the CC port controller, bound to its top-level ports.
  Assumes one pclk domain with async active-low presetn.
*/
// ========
// checker
module typec_cc_chk #(
  parameter CC_DEBOUNCE_CYCLES = 20,
  parameter BUS_POWER_DEBOUNCE_CYCLES = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire irq,
  input wire cur_sel_mid,
  input wire cur_sel_high,
  input wire bus_power_sense,
  input wire cc1_rd_seen,
  input wire cc2_rd_seen,
  input wire [1:0] cc1_rp_level,
  input wire [1:0] cc2_rp_level,
  input wire cc_pullup_en,
  input wire [1:0] rp_level,
  input wire cc_pulldown_en,
  input wire vconn_cc1_en,
  input wire vconn_cc2_en,
  input wire current_ind_a_out,
  input wire current_ind_a_oe_n,
  input wire current_ind_b_out,
  input wire current_ind_b_oe_n,
  input wire orientation_out,
  input wire orientation_oe_n,
  input wire source_attach_flag_out,
  input wire source_attach_flag_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int snk_run;
  int src_run;
  int vb_run;
  int vb_low;
  wire snk_n = current_ind_a_oe_n & current_ind_b_oe_n;
  wire [1:0] sel = {cur_sel_high, cur_sel_mid};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run lengths of raw conditions; a bound one short keeps filter latency choices legal
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snk_run <= 0;
      src_run <= 0;
      vb_run <= 0;
      vb_low <= 0;
    end else begin
      snk_run <= ((cc1_rp_level != 2'h0) ^ (cc2_rp_level != 2'h0)) ? snk_run + 1 : 0;
      src_run <= (cc1_rd_seen ^ cc2_rd_seen) ? src_run + 1 : 0;
      vb_run <= bus_power_sense ? vb_run + 1 : 0;
      vb_low <= bus_power_sense ? 0 : vb_low + 1;
    end
  end
  AST_TERM: assert property (cc_pullup_en != cc_pulldown_en)
    else $error("pull-up and pull-down enables not exclusive");
  AST_RP: assert property ($stable(sel) ##1 ($stable(sel) && cc_pullup_en) |->
    rp_level == (cur_sel_high ? 2'h3 : cur_sel_mid ? 2'h2 : 2'h1))
    else $error("advertised level does not follow select");
  AST_SNK_DB: assert property ($fell(snk_n) |-> snk_run >= CC_DEBOUNCE_CYCLES - 1 &&
    vb_run >= BUS_POWER_DEBOUNCE_CYCLES - 1) else $error("sink attached before debounce");
  AST_SRC_DB: assert property ($fell(source_attach_flag_oe_n) |->
    src_run >= CC_DEBOUNCE_CYCLES - 1) else $error("source attached before debounce");
  AST_SNK_PWR: assert property (!snk_n |-> vb_low <= BUS_POWER_DEBOUNCE_CYCLES + 3)
    else $error("sink stays attached without bus power");
  AST_SRC_IND: assert property (!source_attach_flag_oe_n |->
    snk_n && cc_pullup_en) else $error("indicators or pull-up wrong while source");
  AST_VCONN: assert property (vconn_cc1_en || vconn_cc2_en |-> !source_attach_flag_oe_n &&
    vconn_cc1_en == orientation_oe_n && vconn_cc2_en != orientation_oe_n)
    else $error("vconn on wrong line or while not source");
  AST_OD_LOW: assert property ({current_ind_a_out, current_ind_b_out,
    orientation_out, source_attach_flag_out} == 4'h0) else $error("open-drain data not low");
  AST_ORIENT: assert property ($fell(snk_n) |-> orientation_oe_n == (cc1_rp_level == 2'h0))
    else $error("orientation wrong at sink attach");
  AST_APB: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  COV_SNK: cover property ($fell(snk_n));
  COV_SRC: cover property ($fell(source_attach_flag_oe_n));
  COV_VC: cover property (vconn_cc1_en || vconn_cc2_en);
  COV_IRQ: cover property ($rose(irq));
endmodule // typec_cc_chk

bind typec_cc_port_controller typec_cc_chk #(
  .CC_DEBOUNCE_CYCLES(CC_DEBOUNCE_CYCLES),
  .BUS_POWER_DEBOUNCE_CYCLES(BUS_POWER_DEBOUNCE_CYCLES)
) typec_cc_chk_inst (.*);

// *** verif/remote_port_model.sv ***
/*
  Remote Type-C port seen through the CC comparator inputs and bus power.
  Assumes kind from the bench: 0 none, 1 sink, 2 source, 3 sink behind an Ra cable.
*/
// ========
// remote port
module remote_port_model (
  input wire logic pclk,
  input wire logic [1:0] kind,
  input wire logic orient,
  input wire logic [1:0] level,
  input wire logic pwr,
  input wire logic cc_pullup_en,
  input wire logic cc_pulldown_en,
  output logic cc1_rd_seen = 1'h0,
  output logic cc2_rd_seen = 1'h0,
  output logic cc1_ra_seen = 1'h0,
  output logic cc2_ra_seen = 1'h0,
  output logic [1:0] cc1_rp_level = 2'h0,
  output logic [1:0] cc2_rp_level = 2'h0,
  output logic bus_power_sense = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // a remote Rd only shows while we pull up, a remote Rp only while we pull down
  always @(posedge pclk) begin
    cc1_rd_seen <= kind[0] && cc_pullup_en && !orient;
    cc2_rd_seen <= kind[0] && cc_pullup_en && orient;
    cc1_ra_seen <= kind == 2'h3 && cc_pullup_en && orient;
    cc2_ra_seen <= kind == 2'h3 && cc_pullup_en && !orient;
    cc1_rp_level <= (kind == 2'h2 && cc_pulldown_en && !orient) ? level : 2'h0;
    cc2_rp_level <= (kind == 2'h2 && cc_pulldown_en && orient) ? level : 2'h0;
    bus_power_sense <= pwr;
  end
endmodule // remote_port_model

// *** verif/typec_cc_port_controller_tb_top.sv ***
/*
  Self-checking bench for the CC port controller and a remote port model.
  Assumes shortened debounce and toggle counts as set below.
*/
// ========
// bench
module typec_cc_port_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CCD = 20;
  localparam int TGL = 100;
  localparam int SRC = 30;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic strap_high = 1'h0;
  logic strap_low = 1'h0;
  logic cur_sel_mid = 1'h0;
  logic cur_sel_high = 1'h0;
  logic [1:0] kind = 2'h0;
  logic orient = 1'h0;
  logic [1:0] level = 2'h1;
  logic pwr = 1'h0;
  wire [31:0] prdata;
  wire [1:0] cc1_rp_level, cc2_rp_level, rp_level;
  wire pready, pslverr, irq, bus_power_sense, cc1_rd_seen, cc2_rd_seen, cc1_ra_seen;
  wire cc2_ra_seen, cc_pullup_en, cc_pulldown_en, vconn_cc1_en, vconn_cc2_en;
  wire current_ind_a_out, current_ind_a_oe_n, current_ind_b_out, current_ind_b_oe_n;
  wire orientation_out, orientation_oe_n, source_attach_flag_out, source_attach_flag_oe_n;
  wire snk_n = current_ind_a_oe_n & current_ind_b_oe_n;
  logic [31:0] r, v;
  logic e;
  int i, hi, lo, cyc = 0, fail_count = 0, check_count = 0, seed = 32'h3122_b34a;

  typec_cc_port_controller #(.CC_DEBOUNCE_CYCLES(CCD), .BUS_POWER_DEBOUNCE_CYCLES(5),
    .ROLE_TOGGLE_CYCLES(TGL), .SOURCE_SHARE_CYCLES(SRC)) typec_cc_port_controller_inst (.*);
  remote_port_model remote_port_model_inst (.*);

  initial forever #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      fail_count++;
      $display("[ERR] %0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no local cap: only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rst(input logic h, input logic l);
    presetn <= 1'h0;
    strap_high <= h;
    strap_low <= l;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
  endtask

  task automatic wait_lvl(input logic want, input logic src, input int lim);
    int n;
    n = 0;
    while (((src ? source_attach_flag_oe_n : snk_n) !== want) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    // a wait that runs out is a mismatch of its own
    chk(n < lim, 1'h1);
    #1;
  endtask

  function automatic logic [1:0] ind_exp(input logic [1:0] l);
    return (l == 2'h1) ? 2'h2 : (l == 2'h2) ? 2'h1 : 2'h0;
  endfunction

  function automatic logic [1:0] rp_exp(input logic [1:0] s);
    return s[1] ? 2'h3 : s[0] ? 2'h2 : 2'h1;
  endfunction

  // hang guard, well above the longest scenario
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rst(1'h0, 1'h1);
    repeat (3) @(posedge pclk);
    #1 chk({cc_pullup_en, cc_pulldown_en}, 2'h1);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk({r[5:4], r[2:0]}, 5'h08);
    apb(1'h0, 12'h0f0, 32'h0000_0000);
    chk({e, r[30:0]}, 32'h8000_0000);
    apb(1'h1, 12'h008, 32'h0000_0000);
    chk(e, 1'h1);
    apb(1'h1, 12'h004, 32'h0000_0007);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(r, 32'h0000_0007);
    // late strap change must not move the role
    strap_low <= 1'h0;
    strap_high <= 1'h1;
    v = $random(seed);
    level <= (v[1:0] == 2'h0) ? 2'h3 : v[1:0];
    orient <= v[2];
    pwr <= 1'h1;
    kind <= 2'h2;
    repeat (CCD / 2) @(posedge pclk);
    kind <= 2'h0;
    repeat (CCD + 10) @(posedge pclk);
    #1 chk(snk_n, 1'h1);
    @(posedge pclk);
    kind <= 2'h2;
    wait_lvl(1'h0, 1'h0, 200);
    chk({current_ind_a_oe_n, current_ind_b_oe_n}, ind_exp(level));
    chk(orientation_oe_n, orient);
    chk(irq, 1'h1);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk({r[5:4], r[2:0]}, 5'h0a);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(r[0], 1'h1);
    apb(1'h1, 12'h000, 32'h0000_0007);
    apb(1'h1, 12'h004, 32'h0000_0000);
    chk(irq, 1'h0);
    pwr <= 1'h0;
    wait_lvl(1'h1, 1'h0, 50);
    chk(snk_n, 1'h1);
    chk(orientation_oe_n, 1'h1);
    chk(irq, 1'h0);
    apb(1'h1, 12'h004, 32'h0000_0002);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(r[1], 1'h1);
    chk(irq, 1'h1);
    apb(1'h1, 12'h000, 32'h0000_0007);
    kind <= 2'h0;
    rst(1'h1, 1'h0);
    repeat (3) @(posedge pclk);
    #1 chk({cc_pullup_en, cc_pulldown_en}, 2'h2);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      {cur_sel_high, cur_sel_mid} <= i[1:0];
      repeat (3) @(posedge pclk);
      #1 chk(rp_level, rp_exp(i[1:0]));
    end
    @(posedge pclk);
    v = $random(seed);
    orient <= v[0];
    {cur_sel_high, cur_sel_mid} <= v[2:1];
    kind <= 2'h3;
    wait_lvl(1'h0, 1'h1, 200);
    chk({vconn_cc1_en, vconn_cc2_en}, orient ? 2'h2 : 2'h1);
    chk(orientation_oe_n, orient);
    chk(snk_n, 1'h1);
    @(posedge pclk);
    kind <= 2'h0;
    wait_lvl(1'h1, 1'h1, 100);
    chk({vconn_cc1_en, vconn_cc2_en, orientation_oe_n}, 3'h1);
    @(posedge pclk);
    rst(1'h0, 1'h0);
    while (cc_pullup_en !== 1'h1) @(posedge pclk);
    hi = 0;
    while (cc_pullup_en === 1'h1) begin
      @(posedge pclk);
      hi++;
    end
    lo = 0;
    while (cc_pullup_en === 1'h0) begin
      @(posedge pclk);
      lo++;
    end
    chk(hi, SRC);
    chk(hi + lo, TGL);
    v = $random(seed);
    orient <= v[0];
    kind <= 2'h1;
    wait_lvl(1'h0, 1'h1, 300);
    chk(cc_pullup_en, 1'h1);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk({r[5:4], r[2:0]}, 5'h15);
    wrap_up();
  end
endmodule // typec_cc_port_controller_tb_top
